// ==== mdaf_pkg.sv ====
/*
  Shared constants and types for the modem deviation, frequency correction
  and channel filter configuration bank: register indices, field layouts,
  reset values, arithmetic constants and bus answer codes.
  Assumes nothing of its surroundings; imported by every module of the bank.
*/
package mdaf_pkg;

  // register indices; the byte address is the index shifted by two
  localparam logic [7:0] IDX_TXDEV = 8'h0E;
  localparam logic [7:0] IDX_AFC = 8'h0F;
  localparam logic [7:0] IDX_FILT = 8'h10;
  localparam int unsigned ADDR_SHIFT = 32'h2;

  // transmit deviation layout, msb first
  typedef struct packed {
    logic shaping;          // gaussian pulse shaping enable
    logic [2:0] exponent;   // tx_dev_exponent
    logic [3:0] mantissa;   // tx_dev_mantissa
  } mdaf_txdev_t;

  // frequency correction layout, msb first
  typedef struct packed {
    logic [1:0] settling;   // averaging depth select
    logic [1:0] exponent;   // rx_dev_exponent
    logic [3:0] mantissa;   // rx_dev_mantissa
  } mdaf_afc_t;

  // channel filter layout, msb first
  typedef struct packed {
    logic bypass;           // analog anti-alias filter bypass
    logic [1:0] shift;      // decimator_input_shift
    logic [4:0] divisor;    // decimation_divisor field, divisor minus one
  } mdaf_filt_t;

  // reset values
  localparam mdaf_txdev_t TXDEV_RST = '{1'h1, 3'h6, 4'h8};
  localparam mdaf_afc_t AFC_RST = '{2'h2, 2'h1, 4'hC};
  localparam mdaf_filt_t FILT_RST = '{1'h0, 2'h0, 5'h00};

  // averaging modes and the bit-pair counts they select
  typedef enum logic [1:0] {
    AFC_OFF, AFC_ONE_PAIR, AFC_TWO_PAIRS, AFC_FOUR_PAIRS
  } mdaf_afc_mode_t;
  localparam logic [2:0] PAIRS_NONE = 3'h0;
  localparam logic [2:0] PAIRS_ONE = 3'h1;
  localparam logic [2:0] PAIRS_TWO = 3'h2;
  localparam logic [2:0] PAIRS_FOUR = 3'h4;

  // deviation and filter arithmetic
  localparam int unsigned TX_BIAS_LOW_BAND = 32'h10;
  localparam int unsigned TX_BIAS_HIGH_BAND = 32'hF;
  localparam int unsigned RX_BIAS = 32'h3;
  localparam int unsigned RX_DIVIDE = 32'h3;
  localparam int unsigned BAUD_CLK_DIV = 32'h8;
  localparam logic [31:0] CHAN_BW_BASE_HZ = 32'h0004_B000;

  // register select result of an address decode
  typedef enum logic [1:0] {SEL_NONE, SEL_TXDEV, SEL_AFC, SEL_FILT} mdaf_sel_t;

  // bus answer codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // word address decode, shared by the read and write paths
  function automatic mdaf_sel_t reg_sel(input logic [31:0] addr);
    logic [31:0] word;
    word = addr >> ADDR_SHIFT;
    if (word == 32'(IDX_TXDEV)) return SEL_TXDEV;
    if (word == 32'(IDX_AFC)) return SEL_AFC;
    if (word == 32'(IDX_FILT)) return SEL_FILT;
    return SEL_NONE;
  endfunction

endpackage

// ==== mdaf_tx_dev_calc.sv ====
/*
  Transmit deviation calculator: turns the deviation mantissa and exponent
  into a deviation in Hz for the current band.
  Assumes the reference frequency in Hz and the band select are steady
  levels from the synthesizer section, on the same clock.
*/
`timescale 1ns/1ps
module mdaf_tx_dev_calc
  import mdaf_pkg::*;
#(
  parameter int unsigned SYNTH_REFERENCE_FREQ_W = 32,
  parameter int unsigned DEV_W = 32
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [SYNTH_REFERENCE_FREQ_W-1:0] synth_reference_freq_i,
  input wire logic upper_band_i,
  input wire mdaf_txdev_t txdev_i,
  output logic [DEV_W-1:0] tx_deviation_hz_o
);

  // room for a 4-bit mantissa and a shift of up to seven
  localparam int unsigned PW = SYNTH_REFERENCE_FREQ_W + 11;

  // reference times mantissa, scaled by the exponent and band bias
  wire [PW-1:0] base_w = PW'(synth_reference_freq_i) * PW'(txdev_i.mantissa);
  wire [PW-1:0] scaled_w = base_w << txdev_i.exponent;
  wire [PW-1:0] dev_w = upper_band_i ? (scaled_w >> TX_BIAS_HIGH_BAND)
                                     : (scaled_w >> TX_BIAS_LOW_BAND);

  // registered result; fractions of a Hz are dropped
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_deviation_hz_o <= '0;
    end else begin
      tx_deviation_hz_o <= DEV_W'(dev_w); // RQ3
    end
  end

  // reference model in a different arithmetic form
  function automatic longint ref_dev(input longint f, input longint m,
                                     input longint x, input logic hi);
    return (f * m * (64'h1 << x)) / (hi ? 64'h8000 : 64'h1_0000);
  endfunction

  chk_tx_dev_value: assert property ( // RQ3
    @(posedge sys_clk_i) disable iff (rst_i)
    !$past(rst_i) |-> tx_deviation_hz_o == DEV_W'(ref_dev(
      longint'($past(synth_reference_freq_i)),
      longint'($past(txdev_i.mantissa)), longint'($past(txdev_i.exponent)),
      $past(upper_band_i))))
    else $error("tx deviation does not match mantissa and exponent");

endmodule

// ==== mdaf_rx_path_calc.sv ====
/*
  Receive path calculator: baud rate from the modem clock, expected receive
  deviation, and channel filter bandwidth from the decimation divisor.
  Assumes the modem clock frequency in Hz is a steady level from the clock
  section, on the same clock.
*/
`timescale 1ns/1ps
module mdaf_rx_path_calc
  import mdaf_pkg::*;
#(
  parameter int unsigned CLK_W = 32,
  parameter int unsigned BW_W = 20
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [CLK_W-1:0] modem_clk_hz_i,
  input wire mdaf_afc_t afc_i,
  input wire mdaf_filt_t filt_i,
  output logic [CLK_W-1:0] baud_rate_o,
  output logic [CLK_W-1:0] rx_deviation_hz_o,
  output logic [BW_W-1:0] chan_filter_bw_hz_o
);

  localparam int unsigned PW = CLK_W + 7;

  // baud is the modem clock over eight
  wire [CLK_W-1:0] baud_w = modem_clk_hz_i / CLK_W'(BAUD_CLK_DIV); // RQ16
  // baud times mantissa times two to the (exponent minus three), over three
  wire [PW-1:0] rx_prod_w = (PW'(baud_w) * PW'(afc_i.mantissa))
                            << afc_i.exponent;
  wire [PW-1:0] rx_dev_w = (rx_prod_w >> RX_BIAS) / PW'(RX_DIVIDE);
  // divisor is field plus one, 1 to 32; a divider, not a table, to stay small
  wire [31:0] div_w = 32'(filt_i.divisor) + 32'h1;
  wire [31:0] bw_w = CHAN_BW_BASE_HZ / div_w;

  // all results registered
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      baud_rate_o <= '0;
      rx_deviation_hz_o <= '0;
      chan_filter_bw_hz_o <= '0;
    end else begin
      baud_rate_o <= baud_w; // RQ16
      rx_deviation_hz_o <= CLK_W'(rx_dev_w); // RQ9
      chan_filter_bw_hz_o <= BW_W'(bw_w); // RQ15
    end
  end

  chk_baud_rate: assert property ( // RQ16
    @(posedge sys_clk_i) disable iff (rst_i)
    !$past(rst_i) |-> baud_rate_o == CLK_W'($past(modem_clk_hz_i) >> 3))
    else $error("baud rate is not modem clock over eight");

  chk_rx_dev_value: assert property ( // RQ9
    @(posedge sys_clk_i) disable iff (rst_i)
    !$past(rst_i) |-> rx_deviation_hz_o == CLK_W'(
      (longint'($past(baud_w)) * longint'($past(afc_i.mantissa))
       * (64'h1 << $past(afc_i.exponent))) / 64'h18))
    else $error("rx deviation does not match mantissa and exponent");

  chk_bw_value: assert property ( // RQ15
    @(posedge sys_clk_i) disable iff (rst_i)
    !$past(rst_i) |-> longint'(chan_filter_bw_hz_o) ==
      longint'(307200) / (longint'($past(filt_i.divisor)) + 64'h1))
    else $error("channel filter bandwidth wrong for divisor");

endmodule

// ==== mdaf_cfg_regs.sv ====
/*
  Modem deviation, frequency correction and channel filter configuration
  bank: three byte registers behind an AXI4-Lite slave, with decoded field
  outputs and derived deviation and bandwidth figures.
  Assumes one clock, an asynchronous active-high reset, and steady
  frequency inputs from the synthesizer and clock sections.
*/
// Added by the designer: the AXI4-Lite register port.
// Functional notes
// RQ1 - deviation bit 7 enables gaussian shaping
// RQ2 - tx exponent bits 6:4, mantissa bits 3:0
// RQ3 - tx deviation from reference, mantissa, exponent, band
// RQ4 - zero tx mantissa selects on-off keying
// RQ5 - software keeps tx mantissa within 8 to 15
// RQ6 - averaging field picks off, one, two, four pairs
// RQ7 - software prefers four-pair averaging for accuracy
// RQ8 - rx exponent bits 5:4, mantissa bits 3:0
// RQ9 - rx deviation from baud, mantissa, exponent
// RQ10 - software sets rx deviation versus tx deviation
// RQ11 - filter bit 7 bypasses anti-alias filter
// RQ12 - filter bits 6:5 give decimator input shift
// RQ13 - software picks shift from divisor range
// RQ14 - decimation divisor is field plus one
// RQ15 - filter bandwidth is 307.2 kHz over divisor
// RQ16 - baud rate is modem clock over eight
// RQ17 - byte registers readable, writable, reset, prompt
`timescale 1ns/1ps
module mdaf_cfg_regs
  import mdaf_pkg::*;
#(
  parameter int unsigned AXI_AW = 8,
  parameter int unsigned SYNTH_REFERENCE_FREQ_W = 32,
  parameter int unsigned CLK_W = 32,
  parameter int unsigned BW_W = 20
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // axi4-lite write address
  input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read address
  input wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // figures from the rest of the device
  input wire logic [SYNTH_REFERENCE_FREQ_W-1:0] synth_reference_freq_i,
  input wire logic upper_band_i,
  input wire logic [CLK_W-1:0] modem_clk_hz_i,
  // transmit side controls
  output logic tx_shaping_o,
  output logic [2:0] tx_dev_exponent_o,
  output logic [3:0] tx_dev_mantissa_o,
  output logic ook_mode_o,
  output logic [31:0] tx_deviation_hz_o,
  // frequency correction controls
  output logic afc_enable_o,
  output mdaf_afc_mode_t afc_mode_o,
  output logic [2:0] afc_pairs_o,
  output logic [1:0] rx_dev_exponent_o,
  output logic [3:0] rx_dev_mantissa_o,
  output logic [CLK_W-1:0] baud_rate_o,
  output logic [CLK_W-1:0] rx_deviation_hz_o,
  // channel filter controls
  output logic filter_bypass_o,
  output logic [1:0] decimator_input_shift_o,
  output logic [5:0] decimation_divisor_o,
  output logic [BW_W-1:0] chan_filter_bw_hz_o
);

  // configuration registers
  mdaf_txdev_t txdev_r;     // tx_deviation_setup
  mdaf_txdev_t txdev_nxt;
  mdaf_afc_t afc_r;         // freq_correction_setup
  mdaf_afc_t afc_nxt;
  mdaf_filt_t filt_r;       // channel_filter_setup
  mdaf_filt_t filt_nxt;

  // write channel holding state
  logic aw_held_r;          // write address taken, waiting for data
  logic [AXI_AW-1:0] aw_addr_r;
  logic w_held_r;           // write data taken, waiting for address
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  // read channel state
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // handshake decode
  wire aw_take_w = s_axi_awvalid_i && s_axi_awready_o;
  wire w_take_w = s_axi_wvalid_i && s_axi_wready_o;
  wire ar_take_w = s_axi_arvalid_i && s_axi_arready_o;
  // one write at a time: both halves in, no answer pending
  wire do_write_w = aw_held_r && w_held_r && !bvalid_r;
  // only lane zero carries register data; upper lanes are ignored
  wire lane0_w = do_write_w && w_strb_r[0];

  // address decode for both directions
  wire mdaf_sel_t wr_sel_w = reg_sel(32'(aw_addr_r));
  wire mdaf_sel_t rd_sel_w = reg_sel(32'(s_axi_araddr_i));
  wire wr_txdev_w = lane0_w && (wr_sel_w == SEL_TXDEV);
  wire wr_afc_w = lane0_w && (wr_sel_w == SEL_AFC);
  wire wr_filt_w = lane0_w && (wr_sel_w == SEL_FILT);
  wire [7:0] wr_byte_w = w_data_r[7:0];

  // read data selection; unmapped words read zero
  wire [7:0] rd_byte_w = (rd_sel_w == SEL_TXDEV) ? txdev_r :
                         (rd_sel_w == SEL_AFC) ? afc_r :
                         (rd_sel_w == SEL_FILT) ? filt_r : 8'h00;

  // next register values: whole-byte loads
  assign txdev_nxt = wr_txdev_w ? mdaf_txdev_t'(wr_byte_w) : txdev_r;
  assign afc_nxt = wr_afc_w ? mdaf_afc_t'(wr_byte_w) : afc_r;
  assign filt_nxt = wr_filt_w ? mdaf_filt_t'(wr_byte_w) : filt_r;

  // ready while the holding slot is free and no response is waiting
  assign s_axi_awready_o = !aw_held_r && !bvalid_r;
  assign s_axi_wready_o = !w_held_r && !bvalid_r;
  assign s_axi_arready_o = !rvalid_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  // register bank; fields load defaults at reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      txdev_r <= TXDEV_RST; // RQ1 RQ2
      afc_r <= AFC_RST; // RQ6 RQ8
      filt_r <= FILT_RST; // RQ11 RQ12 RQ14
    end else begin
      txdev_r <= txdev_nxt; // RQ17
      afc_r <= afc_nxt;
      filt_r <= filt_nxt;
    end
  end

  // write address and data are caught in either order
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (aw_take_w) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end else if (do_write_w) begin
        aw_held_r <= 1'b0;
      end
      if (w_take_w) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end else if (do_write_w) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write response; unmapped words answer slave error
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (do_write_w) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_sel_w == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  // read answer is captured in the address cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (ar_take_w) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_byte_w}; // RQ17
      rresp_r <= (rd_sel_w == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

  // field outputs follow the registers directly
  assign tx_shaping_o = txdev_r.shaping; // RQ1
  assign tx_dev_exponent_o = txdev_r.exponent; // RQ2
  assign tx_dev_mantissa_o = txdev_r.mantissa; // RQ2
  // zero tx mantissa means keyed carrier; the rx mantissa plays no part
  assign ook_mode_o = (txdev_r.mantissa == 4'h0); // RQ4
  assign afc_mode_o = mdaf_afc_mode_t'(afc_r.settling); // RQ6
  assign rx_dev_exponent_o = afc_r.exponent; // RQ8
  assign rx_dev_mantissa_o = afc_r.mantissa; // RQ8
  assign filter_bypass_o = filt_r.bypass; // RQ11
  assign decimator_input_shift_o = filt_r.shift; // RQ12
  assign decimation_divisor_o = 6'(filt_r.divisor) + 6'h01; // RQ14

  // averaging off also means a zero average frequency downstream
  always_comb begin
    afc_enable_o = 1'b1;
    case (afc_mode_o)
      AFC_OFF: begin
        afc_enable_o = 1'b0; // RQ6
        afc_pairs_o = PAIRS_NONE;
      end
      AFC_ONE_PAIR: afc_pairs_o = PAIRS_ONE;
      AFC_TWO_PAIRS: afc_pairs_o = PAIRS_TWO;
      AFC_FOUR_PAIRS: afc_pairs_o = PAIRS_FOUR; // RQ6
      default: afc_pairs_o = PAIRS_NONE;
    endcase
  end

  // transmit deviation in Hz for the current band
  mdaf_tx_dev_calc #(
    .SYNTH_REFERENCE_FREQ_W(SYNTH_REFERENCE_FREQ_W),
    .DEV_W(32)
  ) u_tx_dev (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .synth_reference_freq_i(synth_reference_freq_i),
    .upper_band_i(upper_band_i),
    .txdev_i(txdev_r),
    .tx_deviation_hz_o(tx_deviation_hz_o)
  );

  // baud, expected receive deviation and filter bandwidth
  mdaf_rx_path_calc #(
    .CLK_W(CLK_W),
    .BW_W(BW_W)
  ) u_rx_path (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .modem_clk_hz_i(modem_clk_hz_i),
    .afc_i(afc_r),
    .filt_i(filt_r),
    .baud_rate_o(baud_rate_o),
    .rx_deviation_hz_o(rx_deviation_hz_o),
    .chan_filter_bw_hz_o(chan_filter_bw_hz_o)
  );

  // checks, all in the single clock domain
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // register writes, one per register
  sequence s_txdev_write;
    wr_txdev_w;
  endsequence
  sequence s_afc_write;
    wr_afc_w;
  endsequence
  sequence s_filt_write;
    wr_filt_w;
  endsequence
  // first cycle after the reset is released
  sequence s_reset_release;
    $past(rst_i) && !rst_i;
  endsequence

  chk_shaping_write: assert property ( // RQ1
    s_txdev_write |=> tx_shaping_o == $past(wr_byte_w[7]))
    else $error("shaping enable did not follow the write");

  chk_txdev_reset: assert property ( // RQ2
    s_reset_release |-> tx_shaping_o && tx_dev_exponent_o == 3'h6
      && tx_dev_mantissa_o == 4'h8)
    else $error("tx deviation register reset value wrong");

  chk_txdev_fields: assert property ( // RQ2
    s_txdev_write |=> {tx_dev_exponent_o, tx_dev_mantissa_o}
      == $past(wr_byte_w[6:0]))
    else $error("tx exponent or mantissa did not follow the write");

  chk_ook_select: assert property ( // RQ4
    s_txdev_write ##0 (wr_byte_w[3:0] == 4'h0) |=> ook_mode_o
      ##1 (ook_mode_o == (tx_dev_mantissa_o == 4'h0)))
    else $error("on-off keying not selected by zero mantissa");

  chk_afc_off: assert property ( // RQ6
    s_afc_write ##0 (wr_byte_w[7:6] == 2'h0) |=> !afc_enable_o
      && afc_pairs_o == 3'h0)
    else $error("averaging not disabled by zero settling");

  chk_afc_pairs: assert property ( // RQ6
    afc_enable_o |-> (afc_pairs_o == 3'h1 << (afc_r.settling - 2'h1)))
    else $error("averaging pair count wrong for setting");

  chk_afc_reset: assert property ( // RQ8
    s_reset_release |-> afc_pairs_o == 3'h2 && rx_dev_exponent_o == 2'h1
      && rx_dev_mantissa_o == 4'hC)
    else $error("frequency correction reset value wrong");

  chk_rx_fields: assert property ( // RQ8
    s_afc_write |=> {rx_dev_exponent_o, rx_dev_mantissa_o}
      == $past(wr_byte_w[5:0]))
    else $error("rx exponent or mantissa did not follow the write");

  chk_filt_write: assert property ( // RQ11
    s_filt_write |=> filter_bypass_o == $past(wr_byte_w[7])
      && decimator_input_shift_o == $past(wr_byte_w[6:5])) // RQ12
    else $error("bypass or shift did not follow the write");

  chk_div_range: assert property ( // RQ14
    s_filt_write |=> decimation_divisor_o == 6'($past(wr_byte_w[4:0])) + 6'h01
      && decimation_divisor_o inside {[6'h01:6'h20]})
    else $error("decimation divisor is not field plus one");

  // answer offered but not yet taken by the master
  sequence s_resp_waiting;
    s_axi_bvalid_o && !s_axi_bready_i;
  endsequence

  chk_write_answer: assert property ( // RQ17
    do_write_w |=> s_axi_bvalid_o)
    else $error("write response missing after a write");

  // held one edge at a time, so no long repetition is needed
  chk_resp_hold: assert property ( // RQ17
    s_resp_waiting |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before it was taken");

  chk_read_back: assert property ( // RQ17
    ar_take_w && rd_sel_w == SEL_TXDEV |=> s_axi_rvalid_o
      && s_axi_rdata_o == {24'h00_0000, $past(txdev_r)}
      && s_axi_rresp_o == RESP_OKAY)
    else $error("read of tx deviation register returned wrong data");

endmodule

// ==== mdaf_cfg_regs_test.sv ====
/*
  Self-checking bench for the modem deviation, correction and filter bank.
  Assumes the design's own assertions and drives AXI4-Lite from the bench.
*/
`timescale 1ns/1ps
module mdaf_cfg_regs_test;
  import mdaf_pkg::*;
  localparam longint SYNTH_REFERENCE_FREQ_HZ = 1000000; // plain test figure
  localparam longint MCLK_HZ = 3686400; // plain test figure
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic band;
    logic [1:0] resp;
  } mdaf_row_t;
  // byte writes and the answer each should give
  localparam mdaf_row_t ROWS [12] = '{
    '{8'h38, 8'h00, 1'h0, 2'h0}, '{8'h38, 8'h7F, 1'h1, 2'h0},
    '{8'h38, 8'hFF, 1'h0, 2'h0}, '{8'h3C, 8'h00, 1'h0, 2'h0},
    '{8'h3C, 8'hC3, 1'h1, 2'h0}, '{8'h3C, 8'hA8, 1'h0, 2'h0},
    '{8'h3C, 8'hFB, 1'h1, 2'h0}, '{8'h40, 8'h00, 1'h0, 2'h0},
    '{8'h40, 8'hDF, 1'h1, 2'h0}, '{8'h40, 8'h37, 1'h0, 2'h0},
    '{8'h44, 8'hFF, 1'h0, 2'h2}, '{8'h34, 8'h12, 1'h1, 2'h2}};
  logic sys_clk_i, rst_i, awvalid, wvalid, bready, arvalid, rready, band;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic shp, ook, afc_en, byp;
  logic [2:0] txx, pairs;
  logic [3:0] txm, rxm;
  logic [1:0] rxx, shf;
  mdaf_afc_mode_t mode;
  logic [31:0] txdev, baud, rxdev;
  logic [5:0] divi;
  logic [19:0] bw;
  logic [31:0] synth_reference_freq, mclk; // frequency figures driven into the bank
  logic [7:0] shadow [3]; // expected register contents
  int err_total, check_count;
  mdaf_cfg_regs mdaf_cfg_regs_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .synth_reference_freq_i(synth_reference_freq),
    .upper_band_i(band), .modem_clk_hz_i(mclk),
    .tx_shaping_o(shp), .tx_dev_exponent_o(txx), .tx_dev_mantissa_o(txm),
    .ook_mode_o(ook), .tx_deviation_hz_o(txdev), .afc_enable_o(afc_en),
    .afc_mode_o(mode), .afc_pairs_o(pairs), .rx_dev_exponent_o(rxx),
    .rx_dev_mantissa_o(rxm), .baud_rate_o(baud),
    .rx_deviation_hz_o(rxdev), .filter_bypass_o(byp),
    .decimator_input_shift_o(shf), .decimation_divisor_o(divi),
    .chan_filter_bw_hz_o(bw));
  always #50 sys_clk_i = ~sys_clk_i;
  // one comparison, an unknown bit matches only the same unknown; both sides widened to 64 bits
  `define CHK(g, e) \
    begin \
      check_count++; \
      if (64'(g) !== 64'(e)) begin \
        err_total++; \
        $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, 64'(g), \
          64'(e)); \
      end \
    end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                        input logic [3:0] st, output logic [1:0] r);
    int n;
    logic aw, w;
    @(posedge sys_clk_i);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h5A5A5A, d}; // upper bits must be ignored
    wstrb <= st;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk_i);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      err_total++;
      final_report();
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic ar;
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar = 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk_i);
      if (ar && arready) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      err_total++;
      final_report();
    end
  endtask
  // read back all three and check every decoded and derived output
  task automatic check_all();
    logic [31:0] d;
    logic [1:0] r;
    mdaf_txdev_t t;
    mdaf_afc_t a;
    mdaf_filt_t f;
    longint bd;
    longint ex; // expected tx deviation
    for (int i = 0; i < 3; i++) begin
      axi_rd(8'h38 + 8'(4 * i), d, r);
      `CHK(r, RESP_OKAY);
      `CHK(d, {24'h0, shadow[i]});
    end
    t = mdaf_txdev_t'(shadow[0]);
    a = mdaf_afc_t'(shadow[1]);
    f = mdaf_filt_t'(shadow[2]);
    bd = longint'(mclk) / 8;
    ex = ((longint'(synth_reference_freq) * t.mantissa) << t.exponent) >> (band ? 15 : 16);
    `CHK(shp, t.shaping);
    `CHK({txx, txm}, {t.exponent, t.mantissa});
    `CHK(ook, t.mantissa == 4'h0);
    `CHK(txdev, ex);
    `CHK(afc_en, a.settling != 2'h0);
    `CHK(mode, a.settling);
    `CHK(pairs, a.settling == 2'h0 ? 0 : 1 << (a.settling - 1));
    `CHK({rxx, rxm}, {a.exponent, a.mantissa});
    `CHK(baud, bd);
    `CHK(rxdev, (((bd * a.mantissa) << a.exponent) >> 3) / 3);
    `CHK(byp, f.bypass);
    `CHK(shf, f.shift);
    `CHK(divi, f.divisor + 6'h01);
    `CHK(bw, 307200 / (f.divisor + 1));
  endtask
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    sys_clk_i = 1'b0;
    rst_i = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, band} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    err_total = 0;
    check_count = 0;
    synth_reference_freq = 32'(SYNTH_REFERENCE_FREQ_HZ);
    mclk = 32'(MCLK_HZ);
    shadow = '{8'hE8, 8'h9C, 8'h00}; // field defaults
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    check_all();
    // table cases, unmapped writes included, each write followed by a full check
    foreach (ROWS[k]) begin
      band <= ROWS[k].band;
      axi_wr(ROWS[k].addr, ROWS[k].data, 4'h1, r);
      `CHK(r, ROWS[k].resp);
      if (ROWS[k].resp == RESP_OKAY) shadow[ROWS[k].addr[7:2] - 6'h0E] = ROWS[k].data;
      check_all();
    end
    // disabled byte lane leaves the register alone
    axi_wr(8'h38, 8'h11, 4'h0, r);
    `CHK(r, RESP_OKAY);
    check_all();
    // other reference and modem clock figures reach the derived outputs
    synth_reference_freq <= 32'h0200_0000;
    mclk <= 32'h0070_8000;
    check_all();
    // unmapped read answers an error with zero data
    axi_rd(8'h48, d, r);
    `CHK(r, RESP_SLVERR);
    `CHK(d, 32'h0);
    // second reset in mid-run restores the defaults
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    shadow = '{8'hE8, 8'h9C, 8'h00};
    check_all();
    final_report();
  end
endmodule
